/* verilog/nfcd_regs.svh */
/*
 * Constants for the flash command front end: command codes, status bit
 * positions, reset values and the buffer word limit.
 * Assumes inclusion by bare name from design files only.
 */
`ifndef NFCD_REGS_SVH
`define NFCD_REGS_SVH

`define NFCD_CMD_READ_ARRAY 8'hff
`define NFCD_CMD_READ_STATUS 8'h70
`define NFCD_CMD_READ_IDENT 8'h90
`define NFCD_CMD_READ_QUERY 8'h98
`define NFCD_CMD_CLEAR_STATUS 8'h50
`define NFCD_CMD_WORD_PROG 8'h40
`define NFCD_CMD_WORD_PROG_ALT 8'h10
`define NFCD_CMD_BUF_PROG 8'he8
`define NFCD_CMD_CONFIRM 8'hd0
`define NFCD_CMD_FACTORY_SETUP 8'h80
`define NFCD_CMD_ERASE_SETUP 8'h20
`define NFCD_CMD_SUSPEND 8'hb0
`define NFCD_CMD_LOCK_SETUP 8'h60
`define NFCD_CMD_LOCK 8'h01
`define NFCD_CMD_LOCK_DOWN 8'h2f
`define NFCD_CMD_SET_CONFIG 8'h03
`define NFCD_CMD_PROT_SETUP 8'hc0

`define NFCD_SR_READY 7
`define NFCD_SR_ERASE_SUSP 6
`define NFCD_SR_ERASE_ERR 5
`define NFCD_SR_PROG_ERR 4
`define NFCD_SR_PROG_SUSP 2
`define NFCD_SR_RESET 8'h80

`define NFCD_CONFIG_RESET 16'hbfcf
`define NFCD_BUF_MAX_WORDS 32

`endif

/* verilog/nfcd_pkg.sv */
/*
 * Types shared by the flash command front end modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package nfcd_pkg;

   // Read state selected by the last read command.
   typedef enum logic [3:0] {
      NFCD_RD_ARRAY = 4'h1,
      NFCD_RD_STATUS = 4'h2,
      NFCD_RD_IDENT = 4'h4,
      NFCD_RD_QUERY = 4'h8
   } nfcd_rdstate_t;

   // Command sequence state of the front end.
   typedef enum logic [8:0] {
      NFCD_CS_IDLE = 9'h001,
      NFCD_CS_WORD = 9'h002,
      NFCD_CS_BCOUNT = 9'h004,
      NFCD_CS_BDATA = 9'h008,
      NFCD_CS_BCONF = 9'h010,
      NFCD_CS_FSETUP = 9'h020,
      NFCD_CS_FACTORY = 9'h040,
      NFCD_CS_SECOND = 9'h080,
      NFCD_CS_PROT = 9'h100
   } nfcd_cmdstate_t;

   // Operation handed to the write state machine.
   typedef enum logic [2:0] {
      NFCD_OP_WORD = 3'h0,
      NFCD_OP_BUFFER = 3'h1,
      NFCD_OP_FACTORY = 3'h2,
      NFCD_OP_ERASE = 3'h3,
      NFCD_OP_PROT = 3'h4
   } nfcd_op_t;

endpackage

/* verilog/nfcd_stream_if.sv */
/*
 * Valid/ready word stream between the front end and its buffer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface nfcd_stream_if #(parameter int WIDTH = 16);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface

`default_nettype wire

/* verilog/nfcd_fifo.sv */
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none

module nfcd_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic flush,
   nfcd_stream_if.sink inSide,
   nfcd_stream_if.source outSide
);
   localparam int AW = $clog2(DEPTH);

   // Pointer arithmetic only works for power-of-two depths.
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
      $error("DEPTH must be a power of two of at least 2.");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wrPtr_q;
   logic [AW:0] rdPtr_q;
   logic [WIDTH-1:0] outData_q;
   logic outValid_q;

   // Full and empty come straight from the pointers.
   wire isFull = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
   wire isEmpty = (wrPtr_q == rdPtr_q);
   wire doPush = inSide.valid && !isFull;
   wire loadOut = !isEmpty && (!outValid_q || outSide.ready);
   assign inSide.ready = !isFull;
   assign outSide.valid = outValid_q;
   assign outSide.data = outData_q;

   // Storage write; the array itself needs no reset.
   always_ff @(posedge clk) begin
      if (doPush) mem_q[wrPtr_q[AW-1:0]] <= inSide.data;
   end

   // Pointers and the registered output stage.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         outValid_q <= 1'b0;
         outData_q <= '0;
      end else if (flush) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         outValid_q <= 1'b0;
      end else begin
         if (doPush) wrPtr_q <= wrPtr_q + 1'b1;
         if (loadOut) begin
            rdPtr_q <= rdPtr_q + 1'b1;
            outData_q <= mem_q[rdPtr_q[AW-1:0]];
            outValid_q <= 1'b1;
         end else if (outSide.ready) begin
            outValid_q <= 1'b0;
         end
      end
   end

   no_overflow_a: assert property (@(posedge clk) disable iff (!rst_b)
      (AW+1)'(wrPtr_q - rdPtr_q) <= (AW+1)'(DEPTH)) else $error("FIFO holds more words than its depth.");
endmodule

`default_nettype wire

/* verilog/nfcd_command_front_end.sv */
/*
 * Command front end of a parallel NOR flash: decodes command writes, keeps the
 * read state, status word, read configuration and lock bits, and hands program
 * and erase work to the write state machine through start/done handshakes.
 * Assumes host strobes are asynchronous pins and the array engine is on clk.
 */
// Notes on behaviour
// - Code ff selects array reads.
// - Code 70 or accepted operation selects status.
// - Code 90 selects identifier reads.
// - Code 98 selects query reads.
// - Error bits stay until clear-status 50.
// - Word program: setup then address and word.
// - Busy accepts only status read and suspend.
// - Buffered: e8, count, words, then d0.
// - Factory fill: 80, d0, then data only.
// - Erase: 20 then d0 at block address.
// - Erase setup without confirm sets bits 4,5.
// - Code b0 suspends, sets bit 2/6 and 7.
// - Suspend holds until resume d0 or reset.
// - Code d0 while suspended resumes.
// - After 60: 01 lock, d0 unlock, 2f down.
// - Unlock of locked-down block does nothing.
// - Protection program: c0 then address and data.
// - Code 60 then 03 stores address as config.
// - Reset pin aborts running operation.
// - Reset leaves array read state.
// - Reset sets status word to 80.
// - Write captured on first rising strobe.
`timescale 1ns/1ps
`default_nettype none
`include "nfcd_regs.svh"

module nfcd_command_front_end #(
   parameter int ADDR_W = 23,
   parameter int DATA_W = 16,
   parameter int BLOCK_W = 8,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic chipSelect_n,
   input wire logic writeEnable_n,
   input wire logic [ADDR_W-1:0] addrPin,
   input wire logic [DATA_W-1:0] dataPin,
   output nfcd_pkg::nfcd_rdstate_t readState,
   output logic [7:0] statusWord,
   output logic [15:0] readConfigValue,
   output logic [2**BLOCK_W-1:0] blockLocked,
   output logic [2**BLOCK_W-1:0] blockLockedDown,
   output logic opStart,
   output nfcd_pkg::nfcd_op_t opKind,
   output logic [ADDR_W-1:0] wordTargetAddr,
   output logic [DATA_W-1:0] opData,
   output logic [5:0] bufWordCount,
   input wire logic opDone,
   input wire logic opFail,
   input wire logic suspendAck,
   output logic suspendReq,
   output logic resumeReq,
   output logic factoryActive,
   input wire logic factoryExit,
   output logic streamValid,
   output logic [DATA_W-1:0] streamData,
   input wire logic streamReady,
   output logic hostWriteReady
);
   // Refuse widths that the decode and the configuration store cannot serve.
   if (DATA_W < 8 || ADDR_W < 16 || BLOCK_W >= ADDR_W) begin : g_width_check
      $error("Unsupported width parameters.");
   end

   // Strobe pins pass two flip-flops before anything looks at them.
   logic [1:0] ceSync_q;
   logic [1:0] weSync_q;
   logic wrActive_q;
   logic [ADDR_W-1:0] addrSync1_q;
   logic [ADDR_W-1:0] addrSync2_q;
   logic [DATA_W-1:0] dataSync1_q;
   logic [DATA_W-1:0] dataSync2_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ceSync_q <= 2'h3;
         weSync_q <= 2'h3;
         addrSync1_q <= '0;
         addrSync2_q <= '0;
         dataSync1_q <= '0;
         dataSync2_q <= '0;
      end else begin
         ceSync_q <= {ceSync_q[0], chipSelect_n};
         weSync_q <= {weSync_q[0], writeEnable_n};
         addrSync1_q <= addrPin;
         addrSync2_q <= addrSync1_q;
         dataSync1_q <= dataPin;
         dataSync2_q <= dataSync1_q;
      end
   end

   // A write ends when either strobe rises first; bus values are taken then.
   wire writeLow = !ceSync_q[1] && !weSync_q[1];
   wire writeEnd = wrActive_q && !writeLow;
   logic [ADDR_W-1:0] wrAddr_q;
   logic [DATA_W-1:0] wrData_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrActive_q <= 1'b0;
         wrAddr_q <= '0;
         wrData_q <= '0;
      end else begin
         wrActive_q <= writeLow;
         if (writeLow) begin
            wrAddr_q <= addrSync2_q;
            wrData_q <= dataSync2_q;
         end
      end
   end

   nfcd_pkg::nfcd_cmdstate_t cmd_q;
   nfcd_pkg::nfcd_cmdstate_t cmd_d;
   nfcd_pkg::nfcd_rdstate_t rd_q;
   nfcd_pkg::nfcd_rdstate_t rd_d;
   logic [7:0] sr_q;
   logic [7:0] sr_d;
   logic busy_q;
   logic suspended_q;
   logic suspErase_q;
   logic [7:0] second_q;
   logic [5:0] remain_q;

   // Command decode on the low byte of the latched data.
   wire [7:0] code = wrData_q[7:0];
   wire isConfirm = (code == `NFCD_CMD_CONFIRM);
   wire [BLOCK_W-1:0] blk = wrAddr_q[ADDR_W-1 -: BLOCK_W];
   wire inIdle = (cmd_q == nfcd_pkg::NFCD_CS_IDLE);
   wire inFactory = (cmd_q == nfcd_pkg::NFCD_CS_FACTORY);
   wire busyGate = busy_q && !suspended_q;
   wire takeSuspend = writeEnd && inIdle && busyGate && (code == `NFCD_CMD_SUSPEND);
   wire takeResume = writeEnd && inIdle && suspended_q && isConfirm;

   // Buffer stands between host data writes and the program engine.
   nfcd_stream_if #(.WIDTH(DATA_W)) bufIn ();
   nfcd_stream_if #(.WIDTH(DATA_W)) bufOut ();
   wire pushWord = writeEnd && (cmd_q == nfcd_pkg::NFCD_CS_BDATA || inFactory);
   assign bufIn.valid = pushWord;
   assign bufIn.data = wrData_q;
   assign bufOut.ready = streamReady;
   assign streamValid = bufOut.valid;
   assign streamData = bufOut.data;
   assign hostWriteReady = bufIn.ready;
   nfcd_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) dataBuffer (
      .clk(clk),
      .rst_b(rst_b),
      .flush(factoryExit && inFactory),
      .inSide(bufIn.sink),
      .outSide(bufOut.source)
   );

   // Next-state decode of the command sequence.
   logic startOp;
   nfcd_pkg::nfcd_op_t opKind_d;
   always_comb begin
      cmd_d = cmd_q;
      rd_d = rd_q;
      sr_d = sr_q;
      startOp = 1'b0;
      opKind_d = nfcd_pkg::NFCD_OP_WORD;
      if (writeEnd) begin
         case (cmd_q)
            nfcd_pkg::NFCD_CS_IDLE: begin
               if (busyGate) begin
                  if (code == `NFCD_CMD_READ_STATUS) rd_d = nfcd_pkg::NFCD_RD_STATUS;
               end else begin
                  case (code)
                     `NFCD_CMD_READ_ARRAY: rd_d = nfcd_pkg::NFCD_RD_ARRAY;
                     `NFCD_CMD_READ_STATUS: rd_d = nfcd_pkg::NFCD_RD_STATUS;
                     `NFCD_CMD_READ_IDENT: rd_d = nfcd_pkg::NFCD_RD_IDENT;
                     `NFCD_CMD_READ_QUERY: rd_d = nfcd_pkg::NFCD_RD_QUERY;
                     `NFCD_CMD_CLEAR_STATUS: sr_d = sr_q & 8'hc4;
                     `NFCD_CMD_WORD_PROG: cmd_d = nfcd_pkg::NFCD_CS_WORD;
                     `NFCD_CMD_WORD_PROG_ALT: cmd_d = nfcd_pkg::NFCD_CS_WORD;
                     `NFCD_CMD_BUF_PROG: cmd_d = nfcd_pkg::NFCD_CS_BCOUNT;
                     `NFCD_CMD_FACTORY_SETUP: cmd_d = nfcd_pkg::NFCD_CS_FSETUP;
                     `NFCD_CMD_ERASE_SETUP,
                     `NFCD_CMD_LOCK_SETUP: cmd_d = nfcd_pkg::NFCD_CS_SECOND;
                     `NFCD_CMD_PROT_SETUP: cmd_d = nfcd_pkg::NFCD_CS_PROT;
                     default: cmd_d = cmd_q;
                  endcase
               end
            end
            nfcd_pkg::NFCD_CS_WORD: begin
               startOp = 1'b1;
               opKind_d = nfcd_pkg::NFCD_OP_WORD;
               cmd_d = nfcd_pkg::NFCD_CS_IDLE;
            end
            nfcd_pkg::NFCD_CS_PROT: begin
               startOp = 1'b1;
               opKind_d = nfcd_pkg::NFCD_OP_PROT;
               cmd_d = nfcd_pkg::NFCD_CS_IDLE;
            end
            nfcd_pkg::NFCD_CS_BCOUNT: begin
               cmd_d = nfcd_pkg::NFCD_CS_BDATA;
            end
            nfcd_pkg::NFCD_CS_BDATA: begin
               if (remain_q == 6'h0) cmd_d = nfcd_pkg::NFCD_CS_BCONF;
            end
            nfcd_pkg::NFCD_CS_BCONF: begin
               cmd_d = nfcd_pkg::NFCD_CS_IDLE;
               if (isConfirm) begin
                  startOp = 1'b1;
                  opKind_d = nfcd_pkg::NFCD_OP_BUFFER;
               end else begin
                  sr_d[`NFCD_SR_PROG_ERR] = 1'b1;
                  sr_d[`NFCD_SR_ERASE_ERR] = 1'b1;
                  rd_d = nfcd_pkg::NFCD_RD_STATUS;
               end
            end
            nfcd_pkg::NFCD_CS_FSETUP: begin
               if (isConfirm) begin
                  cmd_d = nfcd_pkg::NFCD_CS_FACTORY;
                  startOp = 1'b1;
                  opKind_d = nfcd_pkg::NFCD_OP_FACTORY;
               end else begin
                  cmd_d = nfcd_pkg::NFCD_CS_IDLE;
                  sr_d[`NFCD_SR_PROG_ERR] = 1'b1;
                  sr_d[`NFCD_SR_ERASE_ERR] = 1'b1;
                  rd_d = nfcd_pkg::NFCD_RD_STATUS;
               end
            end
            nfcd_pkg::NFCD_CS_FACTORY: begin
               cmd_d = cmd_q;
            end
            nfcd_pkg::NFCD_CS_SECOND: begin
               cmd_d = nfcd_pkg::NFCD_CS_IDLE;
               if (second_q == `NFCD_CMD_ERASE_SETUP) begin
                  if (isConfirm) begin
                     startOp = 1'b1;
                     opKind_d = nfcd_pkg::NFCD_OP_ERASE;
                  end else begin
                     sr_d[`NFCD_SR_PROG_ERR] = 1'b1;
                     sr_d[`NFCD_SR_ERASE_ERR] = 1'b1;
                     rd_d = nfcd_pkg::NFCD_RD_STATUS;
                  end
               end else if (!(code == `NFCD_CMD_LOCK || isConfirm || code == `NFCD_CMD_LOCK_DOWN
                              || code == `NFCD_CMD_SET_CONFIG)) begin
                  sr_d[`NFCD_SR_PROG_ERR] = 1'b1;
                  sr_d[`NFCD_SR_ERASE_ERR] = 1'b1;
               end else if (code == `NFCD_CMD_SET_CONFIG) begin
                  rd_d = nfcd_pkg::NFCD_RD_ARRAY;
               end
            end
            default: cmd_d = nfcd_pkg::NFCD_CS_IDLE;
         endcase
      end
      if (startOp) rd_d = nfcd_pkg::NFCD_RD_STATUS;
      if (startOp || takeResume) sr_d[`NFCD_SR_READY] = 1'b0;
      if (takeResume) begin
         sr_d[`NFCD_SR_PROG_SUSP] = 1'b0;
         sr_d[`NFCD_SR_ERASE_SUSP] = 1'b0;
      end
      if (suspendAck && busyGate) begin
         sr_d[`NFCD_SR_READY] = 1'b1;
         if (suspErase_q) sr_d[`NFCD_SR_ERASE_SUSP] = 1'b1;
         else sr_d[`NFCD_SR_PROG_SUSP] = 1'b1;
      end
      if (opDone && busyGate) sr_d[`NFCD_SR_READY] = 1'b1;
      if (opFail && busyGate) sr_d[`NFCD_SR_PROG_ERR] = 1'b1;
      if (factoryExit && inFactory) cmd_d = nfcd_pkg::NFCD_CS_IDLE;
   end

   // Sequence, read state and status registers; reset aborts everything.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_q <= nfcd_pkg::NFCD_CS_IDLE;
         rd_q <= nfcd_pkg::NFCD_RD_ARRAY;
         sr_q <= `NFCD_SR_RESET;
         busy_q <= 1'b0;
         suspended_q <= 1'b0;
         suspErase_q <= 1'b0;
         second_q <= 8'h00;
      end else begin
         cmd_q <= cmd_d;
         rd_q <= rd_d;
         sr_q <= sr_d;
         if (writeEnd && inIdle && !busyGate) second_q <= code;
         if (startOp) begin
            busy_q <= 1'b1;
            suspErase_q <= (opKind_d == nfcd_pkg::NFCD_OP_ERASE);
         end else if (opDone && busyGate) begin
            busy_q <= 1'b0;
         end
         if (suspendAck && busyGate) suspended_q <= 1'b1;
         else if (takeResume) suspended_q <= 1'b0;
      end
   end

   // Buffered word count, launch outputs and suspend requests.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         remain_q <= 6'h0;
         bufWordCount <= 6'h0;
         opStart <= 1'b0;
         opKind <= nfcd_pkg::NFCD_OP_WORD;
         wordTargetAddr <= '0;
         opData <= '0;
         suspendReq <= 1'b0;
         resumeReq <= 1'b0;
      end else begin
         if (writeEnd && cmd_q == nfcd_pkg::NFCD_CS_BCOUNT) begin
            remain_q <= wrData_q[5:0];
            bufWordCount <= wrData_q[5:0];
         end else if (pushWord && cmd_q == nfcd_pkg::NFCD_CS_BDATA && remain_q != 6'h0) begin
            remain_q <= remain_q - 6'h1;
         end
         opStart <= startOp;
         if (startOp) begin
            opKind <= opKind_d;
            wordTargetAddr <= wrAddr_q;
            opData <= wrData_q;
         end
         suspendReq <= takeSuspend;
         resumeReq <= takeResume;
      end
   end

   // Read configuration and block lock bits.
   wire lockCycle = writeEnd && cmd_q == nfcd_pkg::NFCD_CS_SECOND && second_q == `NFCD_CMD_LOCK_SETUP;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         readConfigValue <= `NFCD_CONFIG_RESET;
         blockLocked <= '1;
         blockLockedDown <= '0;
      end else if (lockCycle) begin
         if (code == `NFCD_CMD_SET_CONFIG) readConfigValue <= wrAddr_q[15:0];
         if (code == `NFCD_CMD_LOCK) blockLocked[blk] <= 1'b1;
         if (code == `NFCD_CMD_LOCK_DOWN) begin
            blockLocked[blk] <= 1'b1;
            blockLockedDown[blk] <= 1'b1;
         end
         if (isConfirm && !blockLockedDown[blk]) blockLocked[blk] <= 1'b0;
      end
   end

   assign readState = rd_q;
   assign statusWord = sr_q;
   assign factoryActive = inFactory;

   status_on_start_a: assert property (@(posedge clk) disable iff (!rst_b)
      startOp |=> (rd_q == nfcd_pkg::NFCD_RD_STATUS) && !sr_q[`NFCD_SR_READY])
      else $error("Accepted operation did not select status.");
   array_cmd_a: assert property (@(posedge clk) disable iff (!rst_b)
      writeEnd && inIdle && !busyGate && code == `NFCD_CMD_READ_ARRAY |=> rd_q == nfcd_pkg::NFCD_RD_ARRAY)
      else $error("Array read command ignored.");
   busy_filter_a: assert property (@(posedge clk) disable iff (!rst_b)
      writeEnd && inIdle && busyGate && code != `NFCD_CMD_READ_STATUS |=> $stable(rd_q))
      else $error("Command accepted while busy.");
   error_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
      sr_q[`NFCD_SR_PROG_ERR] && !(writeEnd && code == `NFCD_CMD_CLEAR_STATUS) |=> sr_q[`NFCD_SR_PROG_ERR])
      else $error("Error bit dropped without clear.");
   erase_seq_a: assert property (@(posedge clk) disable iff (!rst_b)
      writeEnd && cmd_q == nfcd_pkg::NFCD_CS_SECOND && second_q == `NFCD_CMD_ERASE_SETUP && !isConfirm
      |=> sr_q[5:4] == 2'h3 && rd_q == nfcd_pkg::NFCD_RD_STATUS)
      else $error("Bad erase confirm not flagged.");
   suspend_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      suspended_q && !takeResume |=> suspended_q)
      else $error("Suspend released without resume.");
   suspend_req_a: assert property (@(posedge clk) disable iff (!rst_b)
      takeSuspend |=> suspendReq ##1 !suspendReq)
      else $error("Suspend request not one pulse.");
   lockdown_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
      lockCycle && isConfirm && blockLockedDown[blk] |=> blockLocked[$past(blk)])
      else $error("Locked-down block was unlocked.");
   factory_stay_a: assert property (@(posedge clk) disable iff (!rst_b)
      inFactory && !factoryExit |=> cmd_q == nfcd_pkg::NFCD_CS_FACTORY)
      else $error("Factory fill left without exit.");
   config_store_a: assert property (@(posedge clk) disable iff (!rst_b)
      lockCycle && code == `NFCD_CMD_SET_CONFIG |=> readConfigValue == $past(wrAddr_q[15:0]))
      else $error("Configuration value not stored.");
endmodule

`default_nettype wire

/* bench/nfcd_engine_model.sv */
/* Behavioural write state machine behind the front end.
   Assumes the front end's clock and active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module nfcd_engine_model #(
   parameter int LAT = 60
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic opStart,
   input wire logic suspendReq,
   input wire logic resumeReq,
   input wire logic streamValid,
   input wire logic [15:0] streamData,
   output logic streamReady,
   output logic opDone,
   output logic suspendAck,
   output logic [15:0] lastWord,
   output logic [7:0] wordsTaken
);
   logic [7:0] cnt;
   logic held;
   assign streamReady = 1'b1;
   // Counts a running operation down; a suspend freezes it until resume.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 8'h00;
         held <= 1'b0;
         opDone <= 1'b0;
         suspendAck <= 1'b0;
      end else begin
         opDone <= (cnt == 8'h01) && !held;
         suspendAck <= suspendReq;
         if (opStart)
            cnt <= LAT[7:0];
         else if (cnt != 8'h00 && !held)
            cnt <= cnt - 8'h01;
         if (suspendReq)
            held <= 1'b1;
         else if (resumeReq)
            held <= 1'b0;
      end
   end
   // Takes every buffered word the front end streams out.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wordsTaken <= 8'h00;
         lastWord <= 16'h0000;
      end else if (streamValid) begin
         wordsTaken <= wordsTaken + 8'h01;
         lastWord <= streamData;
      end
   end
endmodule
`default_nettype wire

/* bench/test_nor_flash_command_decoder.sv */
/* Self-checking bench for the command front end.
   Assumes the design files and the engine model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_nor_flash_command_decoder;
   logic clk, rst_b, chipSelect_n, writeEnable_n, opDone, opFail, suspendAck, factoryExit, streamReady;
   logic opStart, suspendReq, resumeReq, factoryActive, streamValid, hostWriteReady, resumeSeen;
   logic [22:0] addrPin, wordTargetAddr, addrSeen;
   logic [15:0] dataPin, readConfigValue, opData, streamData, lastWord, dataSeen;
   logic [7:0] statusWord, wordsTaken;
   logic [255:0] blockLocked, blockLockedDown;
   logic [5:0] bufWordCount;
   nfcd_pkg::nfcd_rdstate_t readState;
   nfcd_pkg::nfcd_op_t opKind, kindSeen;
   int mismatches, check_count, cycles;
   localparam logic [22:0] B = 23'h018000;
   logic [15:0] rd [5] = '{16'h70, 16'h90, 16'h98, 16'h33, 16'hff};
   logic [3:0] rs [5] = '{4'h2, 4'h4, 4'h8, 4'h8, 4'h1};
   logic [15:0] lk [4] = '{16'hd0, 16'h01, 16'h2f, 16'hd0};
   nfcd_command_front_end u_dut (.*);
   nfcd_engine_model u_eng (.*);
   // Free-running clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Records what each operation hand-over carried, and cuts a hang short.
   always @(posedge clk) begin
      cycles++;
      if (opStart === 1'b1) begin
         kindSeen <= opKind;
         addrSeen <= wordTargetAddr;
         dataSeen <= opData;
      end
      if (resumeReq === 1'b1)
         resumeSeen <= 1'b1;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [22:0] a, input logic [15:0] d);
      @(posedge clk);
      chipSelect_n <= 1'b0;
      writeEnable_n <= 1'b0;
      addrPin <= a;
      dataPin <= d;
      repeat (4) @(posedge clk);
      chipSelect_n <= 1'b1;
      writeEnable_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
   task automatic idle(input logic [7:0] exp);
      for (int i = 0; i < 300 && statusWord[7] !== 1'b1; i++) @(posedge clk);
      chk("ready", statusWord, exp);
   endtask
   task automatic close_out;
      if (mismatches == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Main sequence of command writes with expected results.
   initial begin
      {chipSelect_n, writeEnable_n, opFail, factoryExit, rst_b, resumeSeen} = 6'h30;
      addrPin = '0;
      dataPin = '0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("state", readState, 4'h1);
      chk("status", statusWord, 8'h80);
      foreach (rd[i]) begin
         wr(B, rd[i]);
         chk("rdstate", readState, rs[i]);
      end
      wr(23'h1234, 16'h60);
      wr(23'h1234, 16'h03);
      chk("config", {readState, readConfigValue}, 20'h11234);
      foreach (lk[i]) begin
         wr(B, 16'h60);
         wr(B, lk[i]);
         chk("lock", {blockLockedDown[3], blockLocked[3]}, {i > 1, i > 0});
      end
      wr(B, 16'h60);
      wr(B, 16'h55);
      chk("seqerr", statusWord, 8'hb0);
      wr(B, 16'h50);
      wr(B, 16'h20);
      wr(B, 16'hff);
      chk("erserr", {readState, statusWord}, 12'h2b0);
      wr(B, 16'hff);
      chk("sticky", statusWord, 8'hb0);
      wr(B, 16'h50);
      chk("clear", statusWord, 8'h80);
      wr(23'habc, 16'h40);
      wr(23'habc, 16'h5a5a);
      chk("word", {kindSeen, addrSeen, dataSeen}, {3'h0, 23'habc, 16'h5a5a});
      chk("busy", {readState, statusWord[7]}, 5'h4);
      wr(B, 16'h90);
      chk("refuse", readState, 4'h2);
      wr(B, 16'hb0);
      chk("psusp", statusWord, 8'h84);
      wr(B, 16'hd0);
      chk("resume", resumeSeen, 1'b1);
      idle(8'h80);
      wr(B, 16'hff);
      chk("array", readState, 4'h1);
      wr(B, 16'h20);
      wr(B, 16'hd0);
      chk("erase", {kindSeen, addrSeen}, {3'h3, B});
      wr(B, 16'hb0);
      chk("esusp", statusWord, 8'hc0);
      rst_b <= 1'b0;
      @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("abort", {readState, statusWord}, 12'h180);
      wr(B, 16'he8);
      wr(B, 16'h1);
      wr(B, 16'h1111);
      wr(B, 16'h2222);
      wr(B, 16'hd0);
      chk("buffer", {kindSeen, bufWordCount, wordsTaken, lastWord}, {3'h1, 6'h1, 8'h2, 16'h2222});
      chk("room", hostWriteReady, 1'b1);
      idle(8'h80);
      wr(B, 16'hc0);
      wr(B, 16'hbeef);
      chk("prot", {kindSeen, dataSeen}, {3'h4, 16'hbeef});
      opFail <= 1'b1;
      @(posedge clk);
      opFail <= 1'b0;
      idle(8'h90);
      wr(B, 16'h50);
      chk("failclr", statusWord, 8'h80);
      wr(B, 16'h80);
      wr(B, 16'hd0);
      wr(B, 16'h70);
      chk("factory", {factoryActive, kindSeen, wordsTaken, lastWord}, {1'b1, 3'h2, 8'h3, 16'h0070});
      factoryExit <= 1'b1;
      @(posedge clk);
      factoryExit <= 1'b0;
      repeat (2) @(posedge clk);
      chk("fexit", factoryActive, 1'b0);
      close_out();
   end
endmodule
`default_nettype wire
